// File: hral_pkg.sv
package hral_pkg;
    // channel and history geometry
    localparam int NCH = 4;
    localparam int CH_W = 2;
    localparam int MA_CNT = 8;
    localparam int MA_W = 3;
    localparam int RES_W = 16;
    localparam int THR_W = 16;
    localparam int NUM_W = 32;
    // thresholds in units of 0.01 %
    localparam logic [THR_W-1:0] WARN_RST = 16'h012c;
    localparam logic [THR_W-1:0] CRIT_RST = 16'h01f4;
    localparam logic [THR_W-1:0] SUD_RST = 16'h09c4;
    localparam logic [15:0] PCT_SCALE = 16'h2710;
    localparam logic [15:0] RATE_MAX = 16'h7fff;
    localparam logic [5:0] DIV_STEPS = 6'h20;
    // alarm bit layout, three bits per channel
    localparam int AL_WARN = 0;
    localparam int AL_CRIT = 1;
    localparam int AL_SUD = 2;
    localparam int AL_PER_CH = 3;
    localparam int AL_W = 12;
    // register byte offsets
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] OFF_ALARM = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_CANCEL = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_LEVEL = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_WARN = 8'h20;
    localparam logic [ADDR_W-1:0] OFF_CRIT = 8'h30;
    localparam logic [ADDR_W-1:0] OFF_SUD = 8'h40;
    localparam logic [ADDR_W-1:0] OFF_RATE = 8'h50;
    localparam int CANCEL_BIT = 0;
    localparam int LVL_WARN_BIT = 0;
    localparam int LVL_CRIT_BIT = 1;

    typedef struct packed {
        logic valid;
        logic [CH_W-1:0] ch;
        logic [RES_W-1:0] res;
        logic signed [15:0] ref_rate;
        logic stabilized_flag;
        logic waiting;
        logic ref_reg;
        logic calc_ok;
    } hral_smp_s;

    typedef struct packed {
        logic [RES_W-1:0] res;
        logic stabilized_flag;
        logic ok;
    } hral_hent_s;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [ADDR_W-1:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } hral_wbreq_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DIV = 2'b01,
        ST_DONE = 2'b10
    } hral_state_e;
endpackage : hral_pkg

// File: hral_hist.sv
`timescale 1ns/1ns
module hral_hist (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rstn,
    // sample push
    input wire logic i_push,
    input wire hral_pkg::hral_hent_s i_ent,
    // oldest entry and its validity
    output hral_pkg::hral_hent_s o_old,
    output logic o_full,
    output logic o_newer_ok
);
    import hral_pkg::*;

    hral_hent_s ent_reg [MA_CNT];
    logic [MA_W-1:0] wr_ptr_reg;
    logic [MA_W:0] cnt_reg;

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            wr_ptr_reg <= '0;
            cnt_reg <= '0;
        end else if (i_push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (cnt_reg != (MA_W+1)'(MA_CNT)) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            for (int k = 0; k < MA_CNT; k++) begin
                ent_reg[k] <= '0;
            end
        end else if (i_push) begin
            ent_reg[wr_ptr_reg] <= i_ent;
        end
    end

    // slot about to be overwritten is one averaging count back
    assign o_old = ent_reg[wr_ptr_reg];
    assign o_full = (cnt_reg == (MA_W+1)'(MA_CNT));

    always_comb begin
        o_newer_ok = 1'b1;
        for (int k = 0; k < MA_CNT; k++) begin
            if (MA_W'(k) != wr_ptr_reg && !ent_reg[k].ok) begin
                o_newer_ok = 1'b0;
            end
        end
    end
endmodule : hral_hist

// File: hral_div.sv
`timescale 1ns/1ns
module hral_div (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rstn,
    // operands
    input wire logic i_start,
    input wire logic [hral_pkg::NUM_W-1:0] i_num,
    input wire logic [hral_pkg::RES_W-1:0] i_den,
    // result
    output logic o_done,
    output logic [hral_pkg::NUM_W-1:0] o_quo
);
    import hral_pkg::*;

    logic [NUM_W-1:0] num_reg;
    logic [RES_W:0] rem_reg;
    logic [RES_W-1:0] den_reg;
    logic [5:0] step_reg;
    logic [RES_W:0] rem_sh;

    assign rem_sh = {rem_reg[RES_W-1:0], num_reg[NUM_W-1]};

    // restoring division, one quotient bit per cycle
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            num_reg <= '0;
            rem_reg <= '0;
            den_reg <= '0;
            step_reg <= '0;
            o_done <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_start) begin
                num_reg <= i_num;
                rem_reg <= '0;
                den_reg <= i_den;
                step_reg <= DIV_STEPS;
            end else if (step_reg != '0) begin
                step_reg <= step_reg - 1'b1;
                if (rem_sh >= {1'b0, den_reg}) begin
                    rem_reg <= rem_sh - {1'b0, den_reg};
                    num_reg <= {num_reg[NUM_W-2:0], 1'b1};
                end else begin
                    rem_reg <= rem_sh;
                    num_reg <= {num_reg[NUM_W-2:0], 1'b0};
                end
                if (step_reg == 6'h01) begin
                    o_done <= 1'b1;
                end
            end
        end
    end

    assign o_quo = num_reg;
endmodule : hral_div

// File: hral_alarm.sv
`timescale 1ns/1ns
module hral_alarm (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rstn,
    // wishbone slave
    input wire hral_pkg::hral_wbreq_s i_wb,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // measurement samples
    input wire hral_pkg::hral_smp_s i_smp,
    output logic o_smp_ready,
    // alarm outputs
    output logic [hral_pkg::AL_W-1:0] o_alarm,
    output logic o_warn_lvl,
    output logic o_crit_lvl,
    output logic o_irq
);
    import hral_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // decode helpers
    function automatic logic bank_hit(input logic [ADDR_W-1:0] adr,
                                      input logic [ADDR_W-1:0] base);
        return adr[ADDR_W-1:CH_W+2] == base[ADDR_W-1:CH_W+2];
    endfunction : bank_hit

    function automatic logic [CH_W-1:0] bank_ch(
        input logic [ADDR_W-1:0] adr);
        return adr[CH_W+1:2];
    endfunction : bank_ch

    function automatic logic [THR_W-1:0] lane_wr(
        input logic [THR_W-1:0] old, input logic [31:0] dat,
        input logic [3:0] sel);
        logic [THR_W-1:0] v;
        v = old;
        if (sel[0]) begin
            v[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            v[15:8] = dat[15:8];
        end
        return v;
    endfunction : lane_wr

    ////////////////////////////////////////////////////////////////////
    // state
    hral_state_e state_reg;
    hral_smp_s cap_reg;
    logic [THR_W-1:0] warn_reg [NCH];
    logic [THR_W-1:0] crit_reg [NCH];
    logic [THR_W-1:0] sud_reg [NCH];
    logic [15:0] rate_reg [NCH];
    logic rate_neg_reg;
    logic [AL_W-1:0] alarm_reg;
    logic [AL_W-1:0] irq_stat_reg;
    logic [AL_W-1:0] irq_mask_reg;
    logic [AL_W-1:0] set_vec;
    logic [AL_W-1:0] alarm_next;
    logic [AL_W-1:0] irq_stat_next;
    logic wb_go;
    logic wb_wr;
    logic accept;
    logic sud_go;
    logic div_done;
    logic [NUM_W-1:0] div_quo;
    logic [NUM_W-1:0] div_num;
    logic [RES_W-1:0] diff;
    logic cur_ge;
    logic [15:0] quo_sat;
    hral_hent_s old_ent [NCH];
    logic [NCH-1:0] full_vec;
    logic [NCH-1:0] newer_ok_vec;
    hral_hent_s cur_ent;
    hral_hent_s sel_old;

    assign wb_go = i_wb.cyc && i_wb.stb && !o_wb_ack;
    assign wb_wr = i_wb.cyc && i_wb.stb && i_wb.we && o_wb_ack;
    assign accept = i_smp.valid && o_smp_ready;

    ////////////////////////////////////////////////////////////////////
    // per-channel history
    assign cur_ent.res = i_smp.res;
    assign cur_ent.stabilized_flag = i_smp.stabilized_flag;
    assign cur_ent.ok = i_smp.calc_ok;

    for (genvar c = 0; c < NCH; c++) begin : g_hist
        hral_hist u_hist (
            .i_mclk(i_mclk),
            .i_rstn(i_rstn),
            .i_push(accept && i_smp.ch == CH_W'(c)),
            .i_ent(cur_ent),
            .o_old(old_ent[c]),
            .o_full(full_vec[c]),
            .o_newer_ok(newer_ok_vec[c])
        );
    end

    assign sel_old = old_ent[i_smp.ch];

    // earlier sample lies exactly one averaging count back
    always_comb begin
        sud_go = full_vec[i_smp.ch]
            && sel_old.stabilized_flag
            && newer_ok_vec[i_smp.ch] && i_smp.calc_ok
            && (i_smp.stabilized_flag || i_smp.waiting)
            && sel_old.res != '0;
    end

    ////////////////////////////////////////////////////////////////////
    // change-rate arithmetic
    assign cur_ge = i_smp.res >= sel_old.res;
    assign diff = cur_ge ? i_smp.res - sel_old.res
                         : sel_old.res - i_smp.res;
    assign div_num = NUM_W'(diff) * NUM_W'(PCT_SCALE);
    assign quo_sat = (div_quo > NUM_W'(RATE_MAX)) ? RATE_MAX
                                                  : div_quo[15:0];

    hral_div u_div (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_start(accept && sud_go),
        .i_num(div_num),
        .i_den(sel_old.res),
        .o_done(div_done),
        .o_quo(div_quo)
    );

    ////////////////////////////////////////////////////////////////////
    // sample sequencing, one sample in flight
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            state_reg <= ST_IDLE;
            cap_reg <= '0;
            rate_neg_reg <= 1'b0;
            o_smp_ready <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    o_smp_ready <= 1'b1;
                    if (accept) begin
                        cap_reg <= i_smp;
                        rate_neg_reg <= !cur_ge;
                        if (sud_go) begin
                            state_reg <= ST_DIV;
                            o_smp_ready <= 1'b0;
                        end
                    end
                end
                ST_DIV: begin
                    if (div_done) begin
                        state_reg <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_reg <= ST_IDLE;
                    o_smp_ready <= 1'b1;
                end
                default: begin
                    state_reg <= ST_IDLE;
                    o_smp_ready <= 1'b0;
                end
            endcase
        end
    end

    // last rate, two's complement in 0.01 %, host-only readback
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            for (int c = 0; c < NCH; c++) begin
                rate_reg[c] <= '0;
            end
        end else if (state_reg == ST_DIV && div_done) begin
            rate_reg[cap_reg.ch] <= rate_neg_reg ? 16'(-quo_sat)
                                                 : quo_sat;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // alarm decisions
    always_comb begin
        set_vec = '0;
        if (accept && i_smp.stabilized_flag
            && i_smp.ref_reg && !i_smp.ref_rate[15]) begin
            if (16'(i_smp.ref_rate) > warn_reg[i_smp.ch]) begin
                set_vec[i_smp.ch*AL_PER_CH + AL_WARN] = 1'b1;
            end
            if (16'(i_smp.ref_rate) > crit_reg[i_smp.ch]) begin
                set_vec[i_smp.ch*AL_PER_CH + AL_CRIT] = 1'b1;
            end
        end
        if (state_reg == ST_DIV && div_done && !rate_neg_reg
            && quo_sat > sud_reg[cap_reg.ch]) begin
            set_vec[cap_reg.ch*AL_PER_CH + AL_SUD] = 1'b1;
        end
    end

    // a set in the cancel cycle wins
    always_comb begin
        alarm_next = alarm_reg;
        if (wb_wr && i_wb.adr == OFF_CANCEL && i_wb.sel[0]
            && i_wb.dat[CANCEL_BIT]) begin
            alarm_next = '0;
        end
        alarm_next = alarm_next | set_vec;
    end

    always_comb begin
        irq_stat_next = irq_stat_reg;
        if (wb_wr && i_wb.adr == OFF_IRQ_STAT) begin
            irq_stat_next = irq_stat_reg & ~i_wb.dat[AL_W-1:0];
        end
        irq_stat_next = irq_stat_next | set_vec;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            alarm_reg <= '0;
            irq_stat_reg <= '0;
        end else begin
            alarm_reg <= alarm_next;
            irq_stat_reg <= irq_stat_next;
        end
    end

    // output level classes
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_warn_lvl <= 1'b0;
            o_crit_lvl <= 1'b0;
            o_alarm <= '0;
            o_irq <= 1'b0;
        end else begin
            o_warn_lvl <= 1'b0;
            o_crit_lvl <= 1'b0;
            for (int c = 0; c < NCH; c++) begin
                if (alarm_reg[c*AL_PER_CH + AL_WARN]
                    || alarm_reg[c*AL_PER_CH + AL_SUD]) begin
                    o_warn_lvl <= 1'b1;
                end
                if (alarm_reg[c*AL_PER_CH + AL_CRIT]) begin
                    o_crit_lvl <= 1'b1;
                end
            end
            o_alarm <= alarm_reg;
            o_irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register writes
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            irq_mask_reg <= '0;
            for (int c = 0; c < NCH; c++) begin
                warn_reg[c] <= WARN_RST;
                crit_reg[c] <= CRIT_RST;
                sud_reg[c] <= SUD_RST;
            end
        end else if (wb_wr) begin
            if (i_wb.adr == OFF_IRQ_MASK) begin
                if (i_wb.sel[0]) begin
                    irq_mask_reg[7:0] <= i_wb.dat[7:0];
                end
                if (i_wb.sel[1]) begin
                    irq_mask_reg[AL_W-1:8] <= i_wb.dat[AL_W-1:8];
                end
            end
            if (bank_hit(i_wb.adr, OFF_WARN)) begin
                warn_reg[bank_ch(i_wb.adr)] <= lane_wr(
                    warn_reg[bank_ch(i_wb.adr)], i_wb.dat, i_wb.sel);
            end
            if (bank_hit(i_wb.adr, OFF_CRIT)) begin
                crit_reg[bank_ch(i_wb.adr)] <= lane_wr(
                    crit_reg[bank_ch(i_wb.adr)], i_wb.dat, i_wb.sel);
            end
            if (bank_hit(i_wb.adr, OFF_SUD)) begin
                sud_reg[bank_ch(i_wb.adr)] <= lane_wr(
                    sud_reg[bank_ch(i_wb.adr)], i_wb.dat, i_wb.sel);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read path and acknowledge
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= '0;
        end else begin
            o_wb_ack <= wb_go;
            o_wb_dat <= '0;
            if (wb_go && !i_wb.we) begin
                if (i_wb.adr == OFF_ALARM) begin
                    o_wb_dat <= 32'(alarm_reg);
                end
                if (i_wb.adr == OFF_IRQ_STAT) begin
                    o_wb_dat <= 32'(irq_stat_reg);
                end
                if (i_wb.adr == OFF_IRQ_MASK) begin
                    o_wb_dat <= 32'(irq_mask_reg);
                end
                if (i_wb.adr == OFF_LEVEL) begin
                    o_wb_dat[LVL_WARN_BIT] <= o_warn_lvl;
                    o_wb_dat[LVL_CRIT_BIT] <= o_crit_lvl;
                end
                if (bank_hit(i_wb.adr, OFF_WARN)) begin
                    o_wb_dat <= 32'(warn_reg[bank_ch(i_wb.adr)]);
                end
                if (bank_hit(i_wb.adr, OFF_CRIT)) begin
                    o_wb_dat <= 32'(crit_reg[bank_ch(i_wb.adr)]);
                end
                if (bank_hit(i_wb.adr, OFF_SUD)) begin
                    o_wb_dat <= 32'(sud_reg[bank_ch(i_wb.adr)]);
                end
                if (bank_hit(i_wb.adr, OFF_RATE)) begin
                    o_wb_dat <= 32'(rate_reg[bank_ch(i_wb.adr)]);
                end
            end
        end
    end
endmodule : hral_alarm

// File: hral_alarm_properties.sv
`timescale 1ns/1ns
module hral_alarm_props (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rstn,
    // bus
    input wire hral_pkg::hral_wbreq_s i_wb,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    // samples
    input wire hral_pkg::hral_smp_s i_smp,
    input wire logic o_smp_ready,
    // alarms
    input wire logic [hral_pkg::AL_W-1:0] o_alarm,
    input wire logic o_warn_lvl,
    input wire logic o_crit_lvl,
    input wire logic o_irq
);
    import hral_pkg::*;
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rstn);
    ////////////////////////////////////////////////////////////////////////
    logic take;
    logic det_ok;
    logic cancel_wr;
    logic [3:0] cancel_age;
    logic [7:0] since_q;
    assign take = i_smp.valid && o_smp_ready;
    assign det_ok = take && i_smp.stabilized_flag && i_smp.ref_reg;
    assign cancel_wr = i_wb.cyc && i_wb.stb && i_wb.we && i_wb.sel[0]
        && i_wb.adr == OFF_CANCEL && i_wb.dat[0];
    // cycles since a cancel write, saturating
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            cancel_age <= 4'hf;
        end else if (cancel_wr) begin
            cancel_age <= 4'h0;
        end else if (cancel_age != 4'hf) begin
            cancel_age <= cancel_age + 4'h1;
        end
    end
    // cycles since a sample fit for a sudden decision
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            since_q <= 8'hff;
        end else if (take && i_smp.calc_ok
            && (i_smp.stabilized_flag || i_smp.waiting)) begin
            since_q <= 8'h00;
        end else if (since_q != 8'hff) begin
            since_q <= since_q + 8'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held longer than one cycle");
    a_ack_latency: assert property (i_wb.cyc && i_wb.stb && !o_wb_ack
        |=> o_wb_ack) else $error("ack not one cycle after request");
    a_dat_idle: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
        else $error("read data nonzero without ack");
    a_alarm_hold: assert property (
        |($past(o_alarm) & ~o_alarm) |-> cancel_age < 4'h8)
        else $error("alarm cleared without cancel");
    a_warn_level: assert property (
        o_warn_lvl == |(o_alarm & 12'hb6d))
        else $error("warning level mismatch");
    a_crit_level: assert property (o_crit_lvl == |(o_alarm & 12'h492))
        else $error("critical level mismatch");
    a_crit_raise: assert property (
        take && i_smp.stabilized_flag && i_smp.ref_reg && !i_smp.ref_rate[15]
        && i_smp.ref_rate > CRIT_RST
        |-> ##2 o_alarm[3*$past(i_smp.ch, 2)+AL_CRIT])
        else $error("critical alarm not raised");
    a_det_gated: assert property (
        |(o_alarm & ~$past(o_alarm) & 12'h6db)
        |-> $past(det_ok, 2))
        else $error("deterioration alarm without valid sample");
    a_sud_window: assert property (
        |(o_alarm & ~$past(o_alarm) & 12'h924) |-> since_q < 8'd48)
        else $error("sudden alarm without recent fit sample");
    a_ready_drop: assert property (
        $fell(o_smp_ready) |-> $past(i_smp.valid) || $past(i_smp.valid, 2))
        else $error("ready dropped without a sample");
    c_crit: cover property (|(o_alarm & ~$past(o_alarm) & 12'h492));
    c_sud: cover property (|(o_alarm & ~$past(o_alarm) & 12'h924));
    c_cancel: cover property (|($past(o_alarm) & ~o_alarm));
    c_irq: cover property ($rose(o_irq));
endmodule : hral_alarm_props

bind hral_alarm hral_alarm_props hral_alarm_props_i (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_wb(i_wb),
    .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack),
    .i_smp(i_smp),
    .o_smp_ready(o_smp_ready),
    .o_alarm(o_alarm),
    .o_warn_lvl(o_warn_lvl),
    .o_crit_lvl(o_crit_lvl),
    .o_irq(o_irq)
);

// File: hral_meas_model.sv
`timescale 1ns/1ns
module hral_meas_model (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rstn,
    // sample to offer
    input wire logic i_load,
    input wire hral_pkg::hral_smp_s i_next,
    input wire logic i_ready,
    // sample lines
    output hral_pkg::hral_smp_s o_smp,
    output logic o_busy
);
    import hral_pkg::*;
    localparam int SW = $bits(hral_smp_s);
    hral_smp_s held_reg;
    ////////////////////////////////////////////////////////////////////////
    // one strobe per sample, offered only while ready; idle lines toggle
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            held_reg <= '0;
            o_busy <= 1'b0;
            o_smp <= '0;
        end else if (i_load) begin
            held_reg <= i_next;
            o_busy <= 1'b1;
        end else if (o_busy && i_ready && !o_smp.valid) begin
            o_smp <= {1'b1, held_reg[SW-2:0]};
        end else begin
            o_smp <= {1'b0, ~o_smp[SW-2:0]};
            o_busy <= o_busy && !o_smp.valid;
        end
    end
endmodule : hral_meas_model

// File: hral_alarm_test.sv
`timescale 1ns/1ns
module hral_alarm_test;
    import hral_pkg::*;
    logic i_mclk;
    logic i_rstn;
    logic ld;
    logic busy;
    logic wb_ack;
    logic rdy;
    logic warn_l;
    logic crit_l;
    logic irq;
    logic [31:0] wb_dat;
    logic [31:0] rdat;
    logic [AL_W-1:0] alarm;
    hral_wbreq_s wb;
    hral_smp_s smp;
    hral_smp_s nxt;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////////////
    hral_alarm hral_alarm_i (
        .i_mclk(i_mclk), .i_rstn(i_rstn), .i_wb(wb), .o_wb_dat(wb_dat),
        .o_wb_ack(wb_ack), .i_smp(smp), .o_smp_ready(rdy), .o_alarm(alarm),
        .o_warn_lvl(warn_l), .o_crit_lvl(crit_l), .o_irq(irq)
    );
    hral_meas_model hral_meas_model_i (
        .i_mclk(i_mclk), .i_rstn(i_rstn), .i_load(ld), .i_next(nxt),
        .i_ready(rdy), .o_smp(smp), .o_busy(busy)
    );
    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wbx(input logic we, input logic [7:0] a,
                       input logic [31:0] d);
        wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
        // waits for ack; only the cycle ceiling ends this wait if ack never comes
        do begin
            @(posedge i_mclk);
        end while (wb_ack !== 1'b1);
        rdat = wb_dat;
        wb <= '0;
        @(posedge i_mclk);
    endtask : wbx
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wbx(1'b0, a, 32'h0);
        check(rdat, e);
    endtask : rd
    // flags are stabilized_flag, waiting, ref_reg, calc_ok
    task automatic put(input logic [1:0] c, input logic [15:0] r,
                       input logic [15:0] rate, input logic [3:0] f);
        nxt <= '{valid: 1'b1, ch: c, res: r, ref_rate: rate, stabilized_flag: f[3],
                 waiting: f[2], ref_reg: f[1], calc_ok: f[0]};
        ld <= 1'b1;
        @(posedge i_mclk);
        ld <= 1'b0;
        @(posedge i_mclk);
        while (busy !== 1'b0 || rdy !== 1'b1) begin
            @(posedge i_mclk);
        end
        repeat (3) @(posedge i_mclk);
        while (rdy !== 1'b1) begin
            @(posedge i_mclk);
        end
    endtask : put
    task automatic fill(input logic [1:0] c, input int n, input logic [3:0] f);
        for (int i = 0; i < n; i++) begin
            put(c, 16'h03e8, 16'h0000, f);
        end
    endtask : fill
    ////////////////////////////////////////////////////////////////////////
    initial begin
        i_rstn = 1'b0;
        ld = 1'b0;
        wb = '0;
        nxt = '0;
        repeat (4) @(posedge i_mclk);
        i_rstn <= 1'b1;
        @(posedge i_mclk);
        for (int c = 0; c < NCH; c++) begin
            rd(OFF_WARN + 8'(4 * c), 32'h12c);
            rd(OFF_CRIT + 8'(4 * c), 32'h1f4);
            rd(OFF_SUD + 8'(4 * c), 32'h9c4);
        end
        wbx(1'b1, OFF_WARN + 8'h04, 32'h64);
        rd(OFF_WARN + 8'h04, 32'h64);
        rd(OFF_WARN, 32'h12c);
        rd(8'h7c, 32'h0);
        put(2'd0, 16'h03e8, 16'h0190, 4'b0111);
        put(2'd0, 16'h03e8, 16'h0190, 4'b1001);
        put(2'd0, 16'h03e8, 16'h012c, 4'b1011);
        check(32'(alarm), 32'h0);
        put(2'd1, 16'h03e8, 16'h0065, 4'b1011);
        check(32'(alarm), 32'h008);
        put(2'd0, 16'h03e8, 16'h012d, 4'b1011);
        check(32'(alarm), 32'h009);
        check(32'({warn_l, crit_l}), 32'h2);
        rd(OFF_LEVEL, 32'h1);
        put(2'd2, 16'h03e8, 16'h0600, 4'b1011);
        rd(OFF_ALARM, 32'h0c9);
        rd(OFF_LEVEL, 32'h3);
        put(2'd2, 16'h03e8, 16'h0000, 4'b1011);
        wbx(1'b1, OFF_ALARM, 32'h0);
        check(32'(alarm), 32'h0c9);
        check(32'(irq), 32'h0);
        wbx(1'b1, OFF_IRQ_MASK, 32'hfff);
        repeat (2) @(posedge i_mclk);
        check(32'(irq), 32'h1);
        wbx(1'b1, OFF_IRQ_STAT, 32'hfff);
        repeat (2) @(posedge i_mclk);
        check(32'(irq), 32'h0);
        wbx(1'b1, OFF_CANCEL, 32'h1);
        repeat (2) @(posedge i_mclk);
        check(32'(alarm), 32'h0);
        // failed sample inside the window
        fill(2'd1, 8, 4'b1001);
        put(2'd1, 16'h03e8, 16'h0000, 4'b1000);
        put(2'd1, 16'h0514, 16'h0000, 4'b1001);
        // earlier sample taken while waiting
        put(2'd2, 16'h03e8, 16'h0000, 4'b0101);
        fill(2'd2, 7, 4'b1001);
        put(2'd2, 16'h0514, 16'h0000, 4'b1001);
        // current sample neither stabilized nor waiting
        fill(2'd0, 5, 4'b1001);
        put(2'd0, 16'h0514, 16'h0000, 4'b0001);
        check(32'(alarm), 32'h0);
        fill(2'd3, 8, 4'b1001);
        put(2'd3, 16'h0514, 16'h0000, 4'b0101);
        check(32'(alarm), 32'h800);
        check(32'(warn_l), 32'h1);
        rd(OFF_RATE + 8'h0c, 32'hbb8);
        give_verdict();
    end
endmodule : hral_alarm_test
